// [design/sct_defines.vh]
// Constants for the safety cut-out and brake self-test sequencer.
`ifndef SCT_DEFINES_VH
`define SCT_DEFINES_VH
`define SCT_NUM_AXES 4
`define SCT_DIS_BRAKE_BIT 3
`define SCT_DIS_OUT_BIT 12
`define SCT_DIS_WIDTH 16
`define SCT_BRK_ROUTE_BIT 0
`define SCT_CLK_MHZ 50
`define SCT_CHAIN_MS 200
`define SCT_CHAIN_CYC (`SCT_CHAIN_MS * 1000 * `SCT_CLK_MHZ)
`define SCT_SETTLE_CYC 16
`define SCT_ERR_NONE 8'h00
`define SCT_ERR_OUT_MODULE 8'h31
`define SCT_ERR_CHAIN 8'h01
`define SCT_ERR_CUTOUT 8'h02
`define SCT_ERR_OUTPUTS 8'h03
`define SCT_ERR_BRAKE 8'h04
`define SCT_ERR_VOLTAGE 8'h05
`endif

// [design/sct_timer.v]
// Down-counting timeout timer used by the self-test sequencer.
`timescale 1ns/1ps
`default_nettype none
module sct_timer #(
    parameter WIDTH = 24
) (
    input wire mclk_in,
    input wire reset_n_in,
    input wire load_in,
    input wire [WIDTH-1:0] count_in,
    output wire expired_out
);
    reg [WIDTH-1:0] cnt_ff;
    reg [WIDTH-1:0] nxt_cnt;
    always @* begin
        nxt_cnt = cnt_ff;
        if (load_in) begin
            nxt_cnt = count_in;
        end else if (cnt_ff != {WIDTH{1'b0}}) begin
            nxt_cnt = cnt_ff - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end
    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            cnt_ff <= {WIDTH{1'b0}};
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    assign expired_out = (cnt_ff == {WIDTH{1'b0}});
endmodule
`default_nettype wire

// [design/sct_selftest.v]
// Self-test sequencer for cut-out channels, safe outputs and brake control.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.vh"
module sct_selftest #(
    parameter CHAIN_CYC = `SCT_CHAIN_CYC
) (
    input wire mclk_in,
    input wire reset_n_in,
    input wire start_in,
    input wire [`SCT_DIS_WIDTH-1:0] safety_test_disable_param_in,
    input wire [`SCT_DIS_WIDTH-1:0] brake_b_output_param_in,
    input wire contact_chain_fb_a_in,
    input wire contact_chain_fb_b_in,
    input wire [`SCT_NUM_AXES-1:0] module_ready_in,
    input wire safe_outputs_state_in,
    input wire unsupported_out_module_in,
    input wire control_voltage_on_in,
    input wire doors_closed_in,
    input wire auto_safe_mode_in,
    input wire brake_test_fb_a_in,
    input wire brake_test_fb_b_in,
    input wire drive_ctrl_stop_in,
    input wire [`SCT_NUM_AXES-1:0] brake_req_in,
    output reg global_cutout_a_out,
    output reg spindle_cutout_a_out,
    output reg [`SCT_NUM_AXES-1:0] axis_cutout_a_out,
    output reg [`SCT_NUM_AXES-1:0] axis_cutout_b_out,
    output reg estop_input_a_out,
    output reg estop_input_b_out,
    output reg watchdog_off_out,
    output reg [`SCT_NUM_AXES-1:0] brake_a_drive_out,
    output reg [`SCT_NUM_AXES-1:0] brake_b_drive_out,
    output reg [`SCT_NUM_AXES-1:0] brake_b_safe_io_out,
    output reg servo_disable_out,
    output reg prompt_voltage_on_out,
    output reg prompt_close_doors_out,
    output reg immediate_stop_out,
    output reg busy_out,
    output reg pass_out,
    output reg [7:0] error_code_out
);
    localparam [12:0] S_IDLE = 13'h0001;
    localparam [12:0] S_BRK_OFF = 13'h0002;
    localparam [12:0] S_BRK_B = 13'h0004;
    localparam [12:0] S_BRK_A = 13'h0008;
    localparam [12:0] S_VOFF = 13'h0010;
    localparam [12:0] S_VWAIT = 13'h0020;
    localparam [12:0] S_CHAIN = 13'h0040;
    localparam [12:0] S_DOORS = 13'h0080;
    localparam [12:0] S_CUT = 13'h0100;
    localparam [12:0] S_OUTS = 13'h0200;
    localparam [12:0] S_RAISE = 13'h0400;
    localparam [12:0] S_PASS = 13'h0800;
    localparam [12:0] S_FAIL = 13'h1000;
    localparam [31:0] SETTLE_W = `SCT_SETTLE_CYC - 1;
    localparam [3:0] SETTLE = SETTLE_W[3:0];
    localparam [31:0] CHAIN_W = CHAIN_CYC;
    localparam [23:0] CHAIN_LOAD = CHAIN_W[23:0];
    localparam [23:0] SETTLE_LOAD = {20'h0_000, SETTLE};

    reg [12:0] state_ff;
    reg [12:0] nxt_state;
    reg [7:0] err_ff;
    reg [7:0] nxt_err;
    reg tmr_load;
    reg [23:0] tmr_count;
    reg settle_load;
    reg [3:0] settle_ff;
    reg [3:0] nxt_settle;
    reg chain_seen_open_ff;
    reg nxt_chain_seen_open;
    wire tmr_expired;
    wire settled;
    wire chain_closed;
    wire chain_open;
    wire skip_brake;
    wire skip_outs;
    wire route_b_io;
    wire brake_phase;

    sct_timer #(
        .WIDTH(24)
    ) u_timer (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .load_in(tmr_load),
        .count_in(tmr_count),
        .expired_out(tmr_expired)
    );

    assign chain_closed = contact_chain_fb_a_in && contact_chain_fb_b_in;
    assign chain_open = !contact_chain_fb_a_in && !contact_chain_fb_b_in;
    assign skip_brake =
        safety_test_disable_param_in[`SCT_DIS_BRAKE_BIT];
    assign skip_outs = safety_test_disable_param_in[`SCT_DIS_OUT_BIT];
    assign route_b_io = brake_b_output_param_in[`SCT_BRK_ROUTE_BIT];
    assign brake_phase = (state_ff == S_BRK_OFF) || (state_ff == S_BRK_B) ||
        (state_ff == S_BRK_A);
    assign settled = (settle_ff == 4'h0);

    always @* begin
        nxt_settle = settle_ff;
        if (settle_load) begin
            nxt_settle = SETTLE;
        end else if (settle_ff != 4'h0) begin
            nxt_settle = settle_ff - 4'h1;
        end
    end

    always @* begin
        nxt_state = state_ff;
        nxt_err = err_ff;
        tmr_load = 1'b0;
        tmr_count = SETTLE_LOAD;
        settle_load = 1'b0;
        nxt_chain_seen_open = chain_seen_open_ff;
        if (state_ff != nxt_state) begin
            settle_load = 1'b1;
        end
        case (state_ff)
            S_IDLE: begin
                if (start_in) begin
                    nxt_err = `SCT_ERR_NONE;
                    nxt_chain_seen_open = 1'b0;
                    nxt_state = skip_brake ? S_VOFF : S_BRK_OFF;
                end
            end
            S_BRK_OFF: begin
                // Both channels off: feedback must read released.
                if (settled) begin
                    if (brake_test_fb_a_in || brake_test_fb_b_in) begin
                        nxt_err = `SCT_ERR_BRAKE;
                        nxt_state = S_FAIL;
                    end else begin
                        nxt_state = S_BRK_B;
                    end
                end
            end
            S_BRK_B: begin
                if (settled) begin
                    if (!brake_test_fb_b_in || brake_test_fb_a_in) begin
                        nxt_err = `SCT_ERR_BRAKE;
                        nxt_state = S_FAIL;
                    end else begin
                        nxt_state = S_BRK_A;
                    end
                end
            end
            S_BRK_A: begin
                if (settled) begin
                    if (!brake_test_fb_a_in || brake_test_fb_b_in) begin
                        nxt_err = `SCT_ERR_BRAKE;
                        nxt_state = S_FAIL;
                    end else begin
                        nxt_state = S_VOFF;
                    end
                end
            end
            S_VOFF: begin
                if (settled) begin
                    if (control_voltage_on_in) begin
                        nxt_err = `SCT_ERR_VOLTAGE;
                        nxt_state = S_FAIL;
                    end else begin
                        nxt_state = S_VWAIT;
                    end
                end
            end
            S_VWAIT: begin
                if (control_voltage_on_in) begin
                    tmr_load = 1'b1;
                    tmr_count = CHAIN_LOAD;
                    nxt_state = S_CHAIN;
                end
            end
            S_CHAIN: begin
                if (chain_closed) begin
                    nxt_state = S_DOORS;
                end else if (tmr_expired) begin
                    nxt_err = `SCT_ERR_CHAIN;
                    nxt_state = S_FAIL;
                end
            end
            S_DOORS: begin
                if (doors_closed_in && auto_safe_mode_in) begin
                    nxt_state = S_CUT;
                end
            end
            S_CUT: begin
                // All cut-outs low: relays drop, chain closes, ready falls.
                if (settled) begin
                    if (contact_chain_fb_a_in != contact_chain_fb_b_in) begin
                        nxt_err = `SCT_ERR_CUTOUT;
                        nxt_state = S_FAIL;
                    end else if (!chain_closed) begin
                        nxt_err = `SCT_ERR_CUTOUT;
                        nxt_state = S_FAIL;
                    end else if (|module_ready_in) begin
                        nxt_err = `SCT_ERR_CUTOUT;
                        nxt_state = S_FAIL;
                    end else if (skip_outs) begin
                        nxt_state = S_RAISE;
                    end else if (unsupported_out_module_in) begin
                        nxt_err = `SCT_ERR_OUT_MODULE;
                        nxt_state = S_FAIL;
                    end else begin
                        nxt_state = S_OUTS;
                    end
                end
            end
            S_OUTS: begin
                if (safe_outputs_state_in) begin
                    nxt_err = `SCT_ERR_OUTPUTS;
                    nxt_state = S_FAIL;
                end else if (settled) begin
                    nxt_state = S_RAISE;
                end
            end
            S_RAISE: begin
                // Raised global cut-out pulls the relay in and opens the chain.
                if (global_cutout_a_out && chain_open) begin
                    nxt_chain_seen_open = 1'b1;
                end
                if (chain_seen_open_ff) begin
                    nxt_state = S_PASS;
                end else if (tmr_expired) begin
                    nxt_err = `SCT_ERR_CHAIN;
                    nxt_state = S_FAIL;
                end
            end
            S_PASS: begin
                if (start_in) begin
                    nxt_state = S_IDLE;
                end
            end
            S_FAIL: begin
                if (start_in) begin
                    nxt_state = S_IDLE;
                end
            end
            default: begin
                nxt_state = S_FAIL;
            end
        endcase
        if (state_ff == S_CUT && nxt_state == S_RAISE) begin
            tmr_load = 1'b1;
            tmr_count = CHAIN_LOAD;
        end
        if (state_ff == S_OUTS && nxt_state == S_RAISE) begin
            tmr_load = 1'b1;
            tmr_count = CHAIN_LOAD;
        end
        if (drive_ctrl_stop_in && brake_phase) begin
            nxt_err = `SCT_ERR_BRAKE;
            nxt_state = S_FAIL;
        end
        if (nxt_state != state_ff) begin
            settle_load = 1'b1;
        end
    end

    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff <= S_IDLE;
            err_ff <= `SCT_ERR_NONE;
            settle_ff <= 4'h0;
            chain_seen_open_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            err_ff <= nxt_err;
            settle_ff <= nxt_settle;
            chain_seen_open_ff <= nxt_chain_seen_open;
        end
    end

    always @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            global_cutout_a_out <= 1'b0;
            spindle_cutout_a_out <= 1'b0;
            axis_cutout_a_out <= {`SCT_NUM_AXES{1'b0}};
            axis_cutout_b_out <= {`SCT_NUM_AXES{1'b0}};
            estop_input_a_out <= 1'b0;
            estop_input_b_out <= 1'b0;
            watchdog_off_out <= 1'b0;
            brake_a_drive_out <= {`SCT_NUM_AXES{1'b0}};
            brake_b_drive_out <= {`SCT_NUM_AXES{1'b0}};
            brake_b_safe_io_out <= {`SCT_NUM_AXES{1'b0}};
            servo_disable_out <= 1'b0;
            prompt_voltage_on_out <= 1'b0;
            prompt_close_doors_out <= 1'b0;
            immediate_stop_out <= 1'b0;
            busy_out <= 1'b0;
            pass_out <= 1'b0;
            error_code_out <= `SCT_ERR_NONE;
        end else begin
            // Once up in the raise step it stays up while the chain opens.
            global_cutout_a_out <= (nxt_state == S_PASS) ||
                ((nxt_state == S_RAISE) &&
                (chain_closed || global_cutout_a_out));
            spindle_cutout_a_out <= 1'b0;
            axis_cutout_a_out <= {`SCT_NUM_AXES{nxt_state == S_PASS}};
            axis_cutout_b_out <= {`SCT_NUM_AXES{nxt_state == S_PASS}};
            estop_input_a_out <= (nxt_state == S_PASS);
            estop_input_b_out <= (nxt_state == S_PASS);
            watchdog_off_out <= (nxt_state == S_OUTS);
            brake_a_drive_out <= (nxt_state == S_BRK_A) ?
                {`SCT_NUM_AXES{1'b1}} :
                ((nxt_state == S_PASS) ? brake_req_in : {`SCT_NUM_AXES{1'b0}});
            brake_b_drive_out <= route_b_io ? {`SCT_NUM_AXES{1'b0}} :
                ((nxt_state == S_BRK_B) ? {`SCT_NUM_AXES{1'b1}} :
                ((nxt_state == S_PASS) ? brake_req_in :
                {`SCT_NUM_AXES{1'b0}}));
            brake_b_safe_io_out <= !route_b_io ? {`SCT_NUM_AXES{1'b0}} :
                ((nxt_state == S_BRK_B) ? {`SCT_NUM_AXES{1'b1}} :
                ((nxt_state == S_PASS) ? brake_req_in :
                {`SCT_NUM_AXES{1'b0}}));
            servo_disable_out <= (nxt_state == S_BRK_OFF) ||
                (nxt_state == S_BRK_B) || (nxt_state == S_BRK_A);
            prompt_voltage_on_out <= (nxt_state == S_VWAIT);
            prompt_close_doors_out <= (nxt_state == S_DOORS) &&
                !doors_closed_in;
            immediate_stop_out <= (nxt_state == S_FAIL) &&
                (nxt_err == `SCT_ERR_BRAKE);
            busy_out <= (nxt_state != S_IDLE) && (nxt_state != S_PASS) &&
                (nxt_state != S_FAIL);
            pass_out <= (nxt_state == S_PASS);
            error_code_out <= nxt_err;
        end
    end
endmodule
`default_nettype wire

// [tb/sct_assertions.sv]
// Checker of the self-test sequencer port behaviour.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.vh"
module sct_assertions #(
    parameter CHAIN_CYC = `SCT_CHAIN_CYC
) (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic [`SCT_DIS_WIDTH-1:0] brake_b_output_param_in,
    input wire logic contact_chain_fb_a_in,
    input wire logic contact_chain_fb_b_in,
    input wire logic control_voltage_on_in,
    input wire logic global_cutout_a_out,
    input wire logic spindle_cutout_a_out,
    input wire logic estop_input_a_out,
    input wire logic estop_input_b_out,
    input wire logic [`SCT_NUM_AXES-1:0] brake_a_drive_out,
    input wire logic [`SCT_NUM_AXES-1:0] brake_b_drive_out,
    input wire logic [`SCT_NUM_AXES-1:0] brake_b_safe_io_out,
    input wire logic servo_disable_out,
    input wire logic prompt_voltage_on_out,
    input wire logic immediate_stop_out,
    input wire logic busy_out,
    input wire logic pass_out,
    input wire logic [7:0] error_code_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!reset_n_in);
    sequence s_brake_drive;
        busy_out && (|brake_a_drive_out || |brake_b_drive_out
            || |brake_b_safe_io_out);
    endsequence
    property p_spin;
        spindle_cutout_a_out == 1'b0;
    endproperty
    a_spin: assert property (p_spin) else $error("spindle cut-out set");
    property p_pass_clean;
        pass_out |-> !busy_out && !immediate_stop_out && error_code_out == 0;
    endproperty
    a_pass_clean: assert property (p_pass_clean) else $error("bad pass");
    property p_pass_outs;
        pass_out |-> global_cutout_a_out && estop_input_a_out
            && estop_input_b_out;
    endproperty
    a_pass_outs: assert property (p_pass_outs) else $error("run outs");
    property p_gc_chain;
        $rose(global_cutout_a_out) |-> $past(contact_chain_fb_a_in)
            && $past(contact_chain_fb_b_in);
    endproperty
    a_gc_chain: assert property (p_gc_chain) else $error("chain open");
    property p_prompt_v;
        $rose(prompt_voltage_on_out) |-> !$past(control_voltage_on_in);
    endproperty
    a_prompt_v: assert property (p_prompt_v) else $error("volt prompt");
    property p_one_chan;
        busy_out && |brake_a_drive_out |-> brake_b_drive_out == '0
            && brake_b_safe_io_out == '0;
    endproperty
    a_one_chan: assert property (p_one_chan) else $error("two chans");
    property p_servo;
        s_brake_drive |-> servo_disable_out;
    endproperty
    a_servo: assert property (p_servo) else $error("servo active");
    property p_route;
        brake_b_output_param_in[`SCT_BRK_ROUTE_BIT] &&
            $past(brake_b_output_param_in[`SCT_BRK_ROUTE_BIT])
            |-> brake_b_drive_out == '0;
    endproperty
    a_route: assert property (p_route) else $error("b drive routed");
endmodule
bind sct_selftest sct_assertions #(.CHAIN_CYC(CHAIN_CYC)) chk_u (.*);
`default_nettype wire

// [tb/sct_partner.sv]
// Model of the relays, power modules, safe outputs and brake lines.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.vh"
module sct_partner (
    input wire logic mclk_in,
    input wire logic volt_in,
    input wire logic gcut_in,
    input wire logic [`SCT_NUM_AXES-1:0] acut_in,
    input wire logic [`SCT_NUM_AXES-1:0] bcut_in,
    input wire logic wd_off_in,
    input wire logic [`SCT_NUM_AXES-1:0] brk_a_in,
    input wire logic [`SCT_NUM_AXES-1:0] brk_b_in,
    input wire logic [2:0] fault_in,
    output logic chain_out,
    output logic [`SCT_NUM_AXES-1:0] ready_out,
    output logic safe_out,
    output logic fb_a_out,
    output logic fb_b_out
);
    logic [7:0] k1_ff = 8'h00;
    always @(posedge mclk_in) begin
        k1_ff <= {k1_ff[6:0], gcut_in};
        ready_out <= acut_in & bcut_in;
        fb_a_out <= (|brk_a_in) | (fault_in == 3'd2);
        fb_b_out <= |brk_b_in;
    end
    // The chain opens at once and closes only after the slow relay drops.
    assign chain_out = (fault_in == 3'd1)
        | (volt_in & ~(|k1_ff) & (fault_in != 3'd4));
    assign safe_out = (fault_in == 3'd3) | ~wd_off_in;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench of the self-test sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "sct_defines.vh"
module tb;
    typedef struct packed {
        logic [15:0] dis;
        logic bpar;
        logic unsup;
        logic [2:0] fault;
        logic [7:0] exp;
    } sct_row_t;
    localparam NA = `SCT_NUM_AXES;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic start_in = 1'b0;
    logic [15:0] safety_test_disable_param_in = 16'h0000;
    logic [15:0] brake_b_output_param_in = 16'h0000;
    logic contact_chain_fb_a_in, contact_chain_fb_b_in;
    logic safe_outputs_state_in, brake_test_fb_a_in, brake_test_fb_b_in;
    logic [NA-1:0] module_ready_in, brake_req_in = 4'h0;
    logic unsupported_out_module_in = 1'b0;
    logic control_voltage_on_in = 1'b0;
    logic doors_closed_in = 1'b1;
    logic auto_safe_mode_in = 1'b1;
    logic drive_ctrl_stop_in = 1'b0;
    logic global_cutout_a_out, spindle_cutout_a_out, estop_input_a_out;
    logic estop_input_b_out, watchdog_off_out, servo_disable_out;
    logic prompt_voltage_on_out, prompt_close_doors_out, immediate_stop_out;
    logic busy_out, pass_out, chain;
    logic [NA-1:0] axis_cutout_a_out, axis_cutout_b_out, brake_a_drive_out;
    logic [NA-1:0] brake_b_drive_out, brake_b_safe_io_out;
    logic [7:0] error_code_out;
    logic [2:0] fault = 3'd0;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    sct_row_t rows [0:11];
    wire done = pass_out | (|error_code_out);
    assign contact_chain_fb_a_in = chain;
    assign contact_chain_fb_b_in = chain;
    sct_selftest #(.CHAIN_CYC(50)) dut_u (.*);
    sct_partner mdl_u (
        .mclk_in(mclk_in),
        .volt_in(control_voltage_on_in),
        .gcut_in(global_cutout_a_out),
        .acut_in(axis_cutout_a_out),
        .bcut_in(axis_cutout_b_out),
        .wd_off_in(watchdog_off_out),
        .brk_a_in(brake_a_drive_out),
        .brk_b_in(brake_b_drive_out | brake_b_safe_io_out),
        .fault_in(fault),
        .chain_out(chain),
        .ready_out(module_ready_in),
        .safe_out(safe_outputs_state_in),
        .fb_a_out(brake_test_fb_a_in),
        .fb_b_out(brake_test_fb_b_in)
    );
    initial begin
        forever #10 mclk_in = ~mclk_in;
    end
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        tests_run++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            err_count++;
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic run(input sct_row_t r);
        int k;
        safety_test_disable_param_in = r.dis;
        brake_b_output_param_in = {15'h0000, r.bpar};
        unsupported_out_module_in = r.unsup;
        fault = r.fault;
        drive_ctrl_stop_in = r.fault == 3'd5;
        doors_closed_in = r.fault != 3'd6;
        auto_safe_mode_in = r.fault != 3'd6;
        control_voltage_on_in = r.fault == 3'd7;
        @(negedge mclk_in);
        start_in = 1'b1;
        @(negedge mclk_in);
        start_in = 1'b0;
        for (k = 0; k < 900 && !prompt_voltage_on_out && !done; k++)
            @(negedge mclk_in);
        if (r.exp != 8'h04 && r.exp != 8'h05)
            chk("prompt", 16'h0001, {15'h0000, prompt_voltage_on_out});
        control_voltage_on_in = 1'b1;
        for (k = 0; k < 900 && !prompt_close_doors_out && !done; k++)
            @(negedge mclk_in);
        if (r.fault == 3'd6) begin
            repeat (20) @(negedge mclk_in);
            chk("door_hold", 16'h0006,
                {13'h0000, prompt_close_doors_out, busy_out, pass_out});
            doors_closed_in = 1'b1;
            auto_safe_mode_in = 1'b1;
        end
        for (k = 0; k < 900 && !done; k++) @(negedge mclk_in);
        if (r.exp == 8'hff)
            chk("err_any", 16'h0001, {15'h0000, |error_code_out});
        else
            chk("err_code", {8'h00, r.exp}, {8'h00, error_code_out});
        chk("pass_stop", {14'h0000, r.exp == 8'h00, r.exp == 8'h04},
            {14'h0000, pass_out, immediate_stop_out});
        if (r.exp == 8'h00)
            chk("normal", 16'h0ffe, {4'h0, axis_cutout_a_out,
                axis_cutout_b_out, global_cutout_a_out, estop_input_a_out,
                estop_input_b_out, spindle_cutout_a_out});
        start_in = 1'b1;
        @(negedge mclk_in);
        start_in = 1'b0;
        control_voltage_on_in = 1'b0;
        fault = 3'd0;
        repeat (20) @(negedge mclk_in);
        chk("idle", 16'h0000, {14'h0000, busy_out, pass_out});
    endtask
    initial begin
        rows[0] = '{16'h0000, 1'b0, 1'b0, 3'd0, 8'h00};
        rows[1] = '{16'h0008, 1'b1, 1'b0, 3'd2, 8'h00};
        rows[2] = '{16'h0000, 1'b1, 1'b0, 3'd0, 8'h00};
        rows[3] = '{16'h1000, 1'b0, 1'b1, 3'd3, 8'h00};
        rows[4] = '{16'h0000, 1'b0, 1'b1, 3'd0, 8'h31};
        rows[5] = '{16'h0000, 1'b0, 1'b0, 3'd2, 8'h04};
        rows[6] = '{16'h0000, 1'b0, 1'b0, 3'd3, 8'h03};
        rows[7] = '{16'h0000, 1'b0, 1'b0, 3'd1, 8'hff};
        rows[8] = '{16'h0000, 1'b0, 1'b0, 3'd4, 8'hff};
        rows[9] = '{16'h0000, 1'b0, 1'b0, 3'd5, 8'h04};
        rows[10] = '{16'h0000, 1'b0, 1'b0, 3'd6, 8'h00};
        rows[11] = '{16'h0000, 1'b0, 1'b0, 3'd7, 8'h05};
        repeat (5) @(negedge mclk_in);
        chk("reset_outs", 16'h0000, {error_code_out, busy_out, pass_out,
            global_cutout_a_out, immediate_stop_out, 4'h0});
        reset_n_in = 1'b1;
        for (int i = 0; i <= 11; i++) begin
            run(rows[i]);
            $display("test %0d done", i);
        end
        start_in = 1'b1;
        @(negedge mclk_in);
        start_in = 1'b0;
        repeat (20) @(negedge mclk_in);
        chk("brake_b_only", 16'h83c0, {servo_disable_out, watchdog_off_out,
            brake_a_drive_out, brake_b_drive_out, brake_b_safe_io_out,
            2'b00});
        reset_n_in = 1'b0;
        @(negedge mclk_in);
        chk("mid_reset", 16'h0000, {error_code_out, busy_out, pass_out,
            global_cutout_a_out, immediate_stop_out, servo_disable_out,
            3'b000});
        reset_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        chk("after_reset", 16'h0000,
            {14'h0000, busy_out, servo_disable_out});
        $display("test reset done");
        test_done();
    end
endmodule
`default_nettype wire
